// ---- verilog/vpar_defs.vh ----
/*
 * constants for the voltage pwm amplitude regulator: field widths, reset
 * values, timing counts. assumes a 100 MHz core clock.
 */
// Behaviour
// - autoscale samples coil current only in chopper on phase, regulates amplitude.
// - regulator gain setting is the proportional coefficient; least usable gain is one.
// - in tuning phase two the regulator also absorbs velocity-driven amplitude change.
// - autoscale serves both initial tuning and continuous tracking afterwards.
// - regulation only above minimum duty from blank time; blank code 1 is 24 cycles.
// - lower currents come from offset and gradient, tuned or programmed.
// - freewheel option lets coil current fall to zero.
// - in autoscale, sub-limit run and hold scales accepted only after tuning completed.
// - step interval is counted in clock cycles and used as velocity.
// - pure velocity scaling chosen only by writing autoscale enable to 0.
// - amplitude is 8 bits; the sine it scales peaks at 248 of 256.
// - sum is offset*(cs+1)/32 plus gradient*256*fstep/fclk.
// - step frequency normalised to 256 microsteps per full step.
// - current scale term is the scale in effect from hold and run settings.
// - tuned offset and gradient are readable back by the host.
`ifndef VPAR_DEFS_VH
`define VPAR_DEFS_VH
`define VPAR_AMPL_W 8
`define VPAR_AMPL_MAX 8'hff
`define VPAR_SINE_PEAK 8'hf8
`define VPAR_CS_W 5
`define VPAR_CS_MIN_AUTO 5'h06
`define VPAR_STEP_INTERVAL_COUNT_W 20
`define VPAR_STEP_INTERVAL_COUNT_MAX 20'hfffff
`define VPAR_MSTEP_W 4
`define VPAR_GRAD_RST 8'h0e
`define VPAR_OFS_RST 8'h24
`define VPAR_REG_RST 4'h4
`define VPAR_BLANK_BASE 8'h10
`define VPAR_BLANK_STEP 8'h08
`define VPAR_PER_00 11'h400
`define VPAR_PER_01 11'h2ab
`define VPAR_PER_10 11'h200
`define VPAR_PER_11 11'h19a
`endif

// ---- verilog/vpar_step_timer.v ----
/*
 * step interval counter in core clock cycles, scaled to a 256 microstep
 * equivalent. assumes step_i already synchronised, one pulse per step.
 */
`timescale 1ns/10ps
`include "vpar_defs.vh"
module vpar_step_timer
(
    input wire clk_i,
    input wire sys_rst_i,
    input wire step_i,
    input wire [`VPAR_MSTEP_W-1:0] mres_shift_i,
    output reg [`VPAR_STEP_INTERVAL_COUNT_W-1:0] interval_o
);
    reg [`VPAR_STEP_INTERVAL_COUNT_W-1:0] cnt_reg;
    reg [`VPAR_STEP_INTERVAL_COUNT_W+8:0] scaled;
    always @*
    begin
        // coarser steps cover more 256-equivalent steps: divide by 2^shift
        scaled = {9'h000, cnt_reg} >> mres_shift_i;
    end
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_reg <= 20'h00000;
            interval_o <= `VPAR_STEP_INTERVAL_COUNT_MAX;
        end
        else if (step_i)
        begin
            // the step cycle itself counts, so steps n cycles apart read n
            cnt_reg <= 20'h00001;
            interval_o <= (scaled[`VPAR_STEP_INTERVAL_COUNT_W-1:0] == 20'h00000) ? 20'h00001
                : scaled[`VPAR_STEP_INTERVAL_COUNT_W-1:0];
        end
        else
        begin
            if (cnt_reg != `VPAR_STEP_INTERVAL_COUNT_MAX)
                cnt_reg <= cnt_reg + 1'b1;
            else
                interval_o <= `VPAR_STEP_INTERVAL_COUNT_MAX; // standstill: velocity term fades to zero
        end
    end
endmodule // vpar_step_timer

// ---- verilog/vpar_chop_timer.v ----
/*
 * chopper period divider and blank window. one pulse per chopper period,
 * on-phase flag after blanking. assumes select inputs stable while running.
 */
`timescale 1ns/10ps
`include "vpar_defs.vh"
module vpar_chop_timer
(
    input wire clk_i,
    input wire sys_rst_i,
    input wire [1:0] chopper_frequency_select_i,
    input wire [1:0] blank_time_select_i,
    input wire [7:0] duty_i,
    output reg period_o,
    output reg sample_ok_o
);
    reg [10:0] cnt_reg;
    reg hit_reg;
    reg [10:0] per;
    reg [10:0] on_len;
    reg [21:0] on_prod;
    reg [7:0] blank;
    reg in_window;
    always @*
    begin
        case (chopper_frequency_select_i)
            2'h0: per = `VPAR_PER_00;
            2'h1: per = `VPAR_PER_01;
            2'h2: per = `VPAR_PER_10;
            default: per = `VPAR_PER_11;
        endcase
        blank = `VPAR_BLANK_BASE + `VPAR_BLANK_STEP * {6'h00, blank_time_select_i};
        // on time of one half period scales with duty; full-width product, no wrap
        on_prod = {14'h0, duty_i} * {11'h0, per};
        on_len = on_prod[19:9];
        // current is valid only in on phase past blanking: min duty limit
        in_window = ({3'h0, blank} < on_len) && (cnt_reg >= {3'h0, blank})
            && (cnt_reg < on_len);
    end
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_reg <= 11'h000;
            hit_reg <= 1'b0;
            period_o <= 1'b0;
            sample_ok_o <= 1'b0;
        end
        else
        begin
            period_o <= (cnt_reg == per - 1'b1);
            cnt_reg <= (cnt_reg >= per - 1'b1) ? 11'h000 : cnt_reg + 1'b1;
            // window closes before period end: remember it, report with the period pulse
            sample_ok_o <= (cnt_reg == per - 1'b1) && (hit_reg || in_window);
            hit_reg <= (cnt_reg >= per - 1'b1) ? 1'b0 : (hit_reg || in_window);
        end
    end
endmodule // vpar_chop_timer

// ---- verilog/vpar_regulator.v ----
/*
 * voltage pwm amplitude regulator: automatic current-feedback scaling and
 * velocity feed-forward scaling. assumes current error comes from a sense
 * comparator synchronous to clk_i, step pulses from a pin.
 */
`timescale 1ns/10ps
`include "vpar_defs.vh"
module vpar_regulator
(
    input wire clk_i,
    input wire sys_rst_i,
    input wire step_pin_i,
    input wire [`VPAR_MSTEP_W-1:0] mres_shift_i,
    input wire auto_scale_en_i,
    input wire auto_grad_en_i,
    input wire tuning_phase_one_i,
    input wire tuning_phase_two_i,
    input wire freewheel_en_i,
    input wire standstill_i,
    input wire [3:0] reg_gain_i,
    input wire [1:0] blank_time_select_i,
    input wire [1:0] chopper_frequency_select_i,
    input wire [`VPAR_CS_W-1:0] run_current_scale_i,
    input wire [`VPAR_CS_W-1:0] hold_current_scale_i,
    input wire [7:0] amplitude_offset_setting_i,
    input wire [7:0] gradient_setting_i,
    input wire [8:0] current_error_i,
    output reg [`VPAR_AMPL_W-1:0] total_amplitude_o,
    output reg [7:0] auto_amplitude_o,
    output reg [7:0] tuned_offset_readback_o,
    output reg [7:0] tuned_gradient_readback_o,
    output reg [`VPAR_STEP_INTERVAL_COUNT_W-1:0] step_interval_count_o,
    output reg [`VPAR_CS_W-1:0] current_scale_o,
    output reg tuning_done_o,
    output reg amplitude_at_limit_o,
    output reg sine_peak_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_PH1 = 3'b010;
    localparam ST_PH2 = 3'b100;

    reg [2:0] st_reg;
    reg [2:0] st_next;
    reg [2:0] step_sync_reg;
    reg step_level_reg;
    reg step_pulse;
    wire [`VPAR_STEP_INTERVAL_COUNT_W-1:0] interval;
    wire period;
    wire sample_ok;
    reg [`VPAR_CS_W-1:0] cs;
    reg [13:0] ofs_term;
    reg [27:0] grad_term;
    reg [28:0] sum;
    reg [7:0] sum_sat;
    reg signed [13:0] delta;
    reg signed [10:0] auto_ext;
    reg signed [14:0] auto_new;
    reg [7:0] ofs_used;
    reg [7:0] grad_used;
    reg [7:0] auto_mag;
    reg ph1_seen_reg;

    // two-sample agreement of the second and third stages: the first stage is read by the second stage alone
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            step_sync_reg <= 3'b000;
            step_level_reg <= 1'b0;
        end
        else
        begin
            step_sync_reg <= {step_sync_reg[1:0], step_pin_i};
            if (step_sync_reg[1] == step_sync_reg[2])
                step_level_reg <= step_sync_reg[2];
        end
    end

    always @*
    begin
        step_pulse = (step_sync_reg[1] == step_sync_reg[2]) && step_sync_reg[2]
            && !step_level_reg;
    end

    vpar_step_timer u_step
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .step_i(step_pulse),
        .mres_shift_i(mres_shift_i),
        .interval_o(interval)
    );

    vpar_chop_timer u_chop
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .chopper_frequency_select_i(chopper_frequency_select_i),
        .blank_time_select_i(blank_time_select_i),
        .duty_i(total_amplitude_o),
        .period_o(period),
        .sample_ok_o(sample_ok)
    );

    always @*
    begin
        // scale in effect: hold at standstill, run otherwise
        cs = standstill_i ? hold_current_scale_i : run_current_scale_i;
        // in autoscale without tuning done a sub-limit scale is clamped up
        if (auto_scale_en_i && !tuning_done_o && cs < `VPAR_CS_MIN_AUTO)
            cs = `VPAR_CS_MIN_AUTO;
        // tuned offset in autoscale, tuned gradient only with auto gradient on too; programmed values otherwise
        ofs_used = auto_scale_en_i ? tuned_offset_readback_o : amplitude_offset_setting_i;
        grad_used = (auto_scale_en_i && auto_grad_en_i) ? tuned_gradient_readback_o
            : gradient_setting_i;
        // widen before adding one: scale 31 must give 32, not wrap to 0
        ofs_term = ({6'h00, ofs_used} * ({9'h000, cs} + 14'h0001)) >> 5;
        // grad*256*fstep/fclk with fstep/fclk = 1/interval
        grad_term = ({12'h000, grad_used, 8'h00}) / {8'h00, interval};
        sum = {15'h0000, ofs_term} + {1'b0, grad_term};
        // correction is signed: a negative one pulls the sum down, floored at zero
        auto_mag = 8'h00 - auto_amplitude_o;
        if (auto_scale_en_i && !auto_amplitude_o[7])
            sum = sum + {21'h00000, auto_amplitude_o};
        else if (auto_scale_en_i)
            sum = (sum > {21'h00000, auto_mag}) ? sum - {21'h00000, auto_mag}
                : 29'h0000000;
        sum_sat = (sum > {21'h00000, `VPAR_AMPL_MAX}) ? `VPAR_AMPL_MAX : sum[7:0];
        if (freewheel_en_i && standstill_i && hold_current_scale_i == 0)
            sum_sat = 8'h00;
    end

    always @*
    begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE:
                if (auto_scale_en_i && tuning_phase_one_i)
                    st_next = ST_PH1;
                else if (auto_scale_en_i && tuning_phase_two_i && ph1_seen_reg)
                    st_next = ST_PH2;
            ST_PH1:
                if (!tuning_phase_one_i)
                    st_next = ST_IDLE;
            ST_PH2:
                if (!tuning_phase_two_i)
                    st_next = ST_IDLE;
            default:
                st_next = ST_IDLE;
        endcase
    end

    always @*
    begin
        auto_ext = {{3{auto_amplitude_o[7]}}, auto_amplitude_o};
        // gain 0 treated as 1: smallest usable gain
        delta = $signed(current_error_i) * $signed({1'b0, (reg_gain_i == 0) ? 4'h1 : reg_gain_i});
        auto_new = {{4{auto_ext[10]}}, auto_ext} + {delta[13], delta};
    end

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= ST_IDLE;
            ph1_seen_reg <= 1'b0;
            auto_amplitude_o <= 8'h00;
            tuned_offset_readback_o <= `VPAR_OFS_RST;
            tuned_gradient_readback_o <= `VPAR_GRAD_RST;
            tuning_done_o <= 1'b0;
            total_amplitude_o <= 8'h00;
            amplitude_at_limit_o <= 1'b0;
            step_interval_count_o <= `VPAR_STEP_INTERVAL_COUNT_MAX;
            current_scale_o <= 5'h00;
            sine_peak_o <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            total_amplitude_o <= sum_sat;
            amplitude_at_limit_o <= (sum_sat == `VPAR_AMPL_MAX);
            step_interval_count_o <= interval;
            current_scale_o <= cs;
            // peak of sine reachable at amplitude 248 and above
            sine_peak_o <= (sum_sat >= `VPAR_SINE_PEAK);
            // tracking runs whenever autoscale is on, tuning or not
            if (auto_scale_en_i && period && sample_ok)
            begin
                // signed 8-bit correction, saturated, no wrap
                if (auto_new > 15'sd127)
                    auto_amplitude_o <= 8'h7f;
                else if (auto_new < -15'sd128)
                    auto_amplitude_o <= 8'h80;
                else
                    auto_amplitude_o <= auto_new[7:0];
                if (st_reg == ST_PH1 && !auto_amplitude_o[7])
                    tuned_offset_readback_o <= (tuned_offset_readback_o == 8'hff) ?
                        8'hff : tuned_offset_readback_o + 1'b1;
                if (st_reg == ST_PH1 && auto_amplitude_o[7] && tuned_offset_readback_o != 0)
                    tuned_offset_readback_o <= tuned_offset_readback_o - 1'b1;
                // velocity error absorbed and folded into gradient
                if (st_reg == ST_PH2 && auto_grad_en_i && step_pulse == 1'b0)
                begin
                    if (!auto_amplitude_o[7] && auto_amplitude_o != 0
                        && tuned_gradient_readback_o != 8'hff)
                        tuned_gradient_readback_o <= tuned_gradient_readback_o + 1'b1;
                    else if (auto_amplitude_o[7] && tuned_gradient_readback_o != 0)
                        tuned_gradient_readback_o <= tuned_gradient_readback_o - 1'b1;
                end
            end
            if (st_reg == ST_PH1 && st_next == ST_IDLE)
                ph1_seen_reg <= 1'b1;
            if (st_reg == ST_PH2 && st_next == ST_IDLE)
                tuning_done_o <= 1'b1;
            if (!auto_scale_en_i)
                auto_amplitude_o <= 8'h00;
        end
    end
endmodule // vpar_regulator

// ---- testbench/vpar_regulator_monitor.sv ----
/*
 * port checker for vpar_regulator: scale selection, freewheel, saturation
 * flags, reset readback, step interval cause. assumes bind from the bench.
 */
`timescale 1ns/10ps
module vpar_regulator_monitor
(
    input wire clk_i,
    input wire sys_rst_i,
    input wire step_pin_i,
    input wire auto_scale_en_i,
    input wire standstill_i,
    input wire freewheel_en_i,
    input wire [4:0] run_current_scale_i,
    input wire [4:0] hold_current_scale_i,
    input wire [7:0] total_amplitude_o,
    input wire [7:0] tuned_offset_readback_o,
    input wire [7:0] tuned_gradient_readback_o,
    input wire [19:0] step_interval_count_o,
    input wire [4:0] current_scale_o,
    input wire tuning_done_o,
    input wire amplitude_at_limit_o,
    input wire sine_peak_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_low_run;
        auto_scale_en_i && !standstill_i && !tuning_done_o && run_current_scale_i < 5'h06;
    endsequence
    sequence s_run_sel;
        !auto_scale_en_i && !standstill_i;
    endsequence
    sequence s_hold_sel;
        !auto_scale_en_i && standstill_i;
    endsequence
    property p_clamp;
        s_low_run ##1 s_low_run |-> current_scale_o == 5'h06;
    endproperty
    a_clamp: assert property (p_clamp) else $error("low run scale not clamped");
    property p_run_scale;
        s_run_sel ##1 (s_run_sel and $stable(run_current_scale_i))
            |-> current_scale_o == run_current_scale_i;
    endproperty
    a_run_scale: assert property (p_run_scale) else $error("run scale not in effect");
    property p_hold_scale;
        s_hold_sel ##1 (s_hold_sel and $stable(hold_current_scale_i))
            |-> current_scale_o == hold_current_scale_i;
    endproperty
    a_hold_scale: assert property (p_hold_scale) else $error("hold scale not in effect");
    property p_freewheel;
        (freewheel_en_i && standstill_i && hold_current_scale_i == 5'h00) [*2]
            |-> total_amplitude_o == 8'h00;
    endproperty
    a_freewheel: assert property (p_freewheel) else $error("freewheel amplitude not zero");
    property p_limit;
        amplitude_at_limit_o |-> total_amplitude_o == 8'hff || $past(total_amplitude_o) == 8'hff;
    endproperty
    a_limit: assert property (p_limit) else $error("limit flag without full sum");
    property p_peak;
        sine_peak_o |-> total_amplitude_o >= 8'hf8 || $past(total_amplitude_o) >= 8'hf8;
    endproperty
    a_peak: assert property (p_peak) else $error("peak flag below peak code");
    property p_done_sticky;
        tuning_done_o |=> tuning_done_o;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("tuning done dropped");
    property p_rst_vals;
        $fell(sys_rst_i) |-> tuned_offset_readback_o == 8'h24
            && tuned_gradient_readback_o == 8'h0e && step_interval_count_o == 20'hfffff;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("wrong readback after reset");
    property p_interval_cause;
        $changed(step_interval_count_o) |-> $past(step_pin_i, 4) || $past(step_pin_i, 5)
            || step_interval_count_o == 20'hfffff;
    endproperty
    a_interval_cause: assert property (p_interval_cause) else $error("interval moved without step");
endmodule // vpar_regulator_monitor

// ---- testbench/vpar_coil_model.sv ----
/*
 * coil sense model: measured current follows the applied amplitude a
 * cycle late. assumes amplitude and target on the core clock.
 */
`timescale 1ns/10ps
module vpar_coil_model
(
    input wire clk_i,
    input wire [7:0] amplitude_i,
    input wire [7:0] target_i,
    output reg [8:0] current_error_o = 9'h000
);
    // sense lags the bridge by a cycle, as real copper would
    always @(posedge clk_i)
    begin
        current_error_o <= {1'b0, target_i} - {1'b0, amplitude_i};
    end
endmodule // vpar_coil_model

// ---- testbench/vpar_regulator_tb.sv ----
/*
 * self-checking bench for vpar_regulator with the coil sense model.
 * assumes the monitor and model are compiled before this file.
 */
`timescale 1ns/10ps
module vpar_regulator_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic step_pin_i = 1'b0;
    logic [3:0] mres_shift_i = 4'h0;
    logic auto_scale_en_i = 1'b0;
    logic auto_grad_en_i = 1'b0;
    logic tuning_phase_one_i = 1'b0;
    logic tuning_phase_two_i = 1'b0;
    logic freewheel_en_i = 1'b0;
    logic standstill_i = 1'b0;
    logic [3:0] reg_gain_i = 4'h4;
    logic [1:0] blank_time_select_i = 2'h1;
    logic [1:0] chopper_frequency_select_i = 2'h3;
    logic [4:0] run_current_scale_i = 5'h1f;
    logic [4:0] hold_current_scale_i = 5'h00;
    logic [7:0] amplitude_offset_setting_i = 8'h00;
    logic [7:0] gradient_setting_i = 8'h00;
    logic [7:0] target_i = 8'hc8;
    wire [8:0] current_error_i;
    wire [7:0] total_amplitude_o, auto_amplitude_o;
    wire [7:0] tuned_offset_readback_o, tuned_gradient_readback_o;
    wire [19:0] step_interval_count_o;
    wire [4:0] current_scale_o;
    wire tuning_done_o, amplitude_at_limit_o, sine_peak_o;
    integer err_total = 0;
    integer cmp_count = 0;
    vpar_regulator dut
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .step_pin_i(step_pin_i),
        .mres_shift_i(mres_shift_i),
        .auto_scale_en_i(auto_scale_en_i),
        .auto_grad_en_i(auto_grad_en_i),
        .tuning_phase_one_i(tuning_phase_one_i),
        .tuning_phase_two_i(tuning_phase_two_i),
        .freewheel_en_i(freewheel_en_i),
        .standstill_i(standstill_i),
        .reg_gain_i(reg_gain_i),
        .blank_time_select_i(blank_time_select_i),
        .chopper_frequency_select_i(chopper_frequency_select_i),
        .run_current_scale_i(run_current_scale_i),
        .hold_current_scale_i(hold_current_scale_i),
        .amplitude_offset_setting_i(amplitude_offset_setting_i),
        .gradient_setting_i(gradient_setting_i),
        .current_error_i(current_error_i),
        .total_amplitude_o(total_amplitude_o),
        .auto_amplitude_o(auto_amplitude_o),
        .tuned_offset_readback_o(tuned_offset_readback_o),
        .tuned_gradient_readback_o(tuned_gradient_readback_o),
        .step_interval_count_o(step_interval_count_o),
        .current_scale_o(current_scale_o),
        .tuning_done_o(tuning_done_o),
        .amplitude_at_limit_o(amplitude_at_limit_o),
        .sine_peak_o(sine_peak_o)
    );
    vpar_coil_model u_coil (.clk_i(clk_i), .amplitude_i(total_amplitude_o),
        .target_i(target_i), .current_error_o(current_error_i));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic tick(input integer n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic ok, input string what);
        cmp_count = cmp_count + 1;
        if (ok !== 1'b1)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // truncating divides, saturated at the top code
    function automatic logic [19:0] exp_sum(input logic [7:0] ofs, input logic [4:0] cs,
        input logic [7:0] grad, input logic [19:0] ivl);
        logic [19:0] s;
        s = (ofs * (cs + 20'h1)) / 20'h20 + (grad * 20'h100) / ivl;
        return (s > 20'hff) ? 20'hff : s;
    endfunction
    task automatic steps(input integer n);
        repeat (n)
        begin
            step_pin_i = 1'b1;
            tick(4);
            step_pin_i = 1'b0;
            tick(996);
        end
    endtask
    task automatic vel_case(input logic [7:0] ofs, input logic [4:0] run,
        input logic [4:0] hold, input logic ss);
        logic [4:0] cs;
        cs = ss ? hold : run;
        amplitude_offset_setting_i = ofs;
        run_current_scale_i = run;
        hold_current_scale_i = hold;
        standstill_i = ss;
        tick(3);
        chk(current_scale_o === cs, "scale in effect");
        chk(total_amplitude_o === exp_sum(ofs, cs, 8'h00, 20'hfffff), "offset sum");
    endtask
    task automatic t_velocity;
        vel_case(8'h40, 5'h1f, 5'h07, 1'b0);
        vel_case(8'h40, 5'h1f, 5'h07, 1'b1);
        vel_case(8'hff, 5'h00, 5'h00, 1'b0);
        vel_case(8'h40, 5'h1f, 5'h00, 1'b1);
        freewheel_en_i = 1'b1;
        tick(3);
        chk(total_amplitude_o === 8'h00, "freewheel");
        freewheel_en_i = 1'b0;
        standstill_i = 1'b0;
    endtask
    task automatic t_steps;
        amplitude_offset_setting_i = 8'h00;
        gradient_setting_i = 8'hff;
        steps(3);
        chk(step_interval_count_o === 20'h003e8, "interval");
        chk(total_amplitude_o === exp_sum(8'h00, 5'h1f, 8'hff, 20'h003e8), "grad sum");
        mres_shift_i = 4'h3;
        gradient_setting_i = 8'h20;
        steps(3);
        chk(step_interval_count_o === 20'h0007d, "scaled interval");
        chk(total_amplitude_o === exp_sum(8'h00, 5'h1f, 8'h20, 20'h0007d), "scaled sum");
        amplitude_offset_setting_i = 8'hff;
        tick(3);
        chk(total_amplitude_o === 8'hff && amplitude_at_limit_o === 1'b1, "saturation");
        amplitude_offset_setting_i = 8'hf8;
        gradient_setting_i = 8'h00;
        tick(3);
        chk(total_amplitude_o === 8'hf8, "peak sum");
        chk(sine_peak_o === 1'b1 && amplitude_at_limit_o === 1'b0, "peak flags");
    endtask
    task automatic t_regulate;
        logic [7:0] a0;
        auto_scale_en_i = 1'b1;
        auto_grad_en_i = 1'b1;
        tick(3);
        a0 = total_amplitude_o;
        tick(12300);
        chk(total_amplitude_o > a0, "regulation toward target");
        chk(auto_amplitude_o === 8'h7f, "correction saturated high");
    endtask
    task automatic t_tuning;
        integer n;
        run_current_scale_i = 5'h02;
        tick(3);
        chk(current_scale_o === 5'h06, "clamp");
        run_current_scale_i = 5'h1f;
        tuning_phase_one_i = 1'b1;
        tick(2000);
        tuning_phase_one_i = 1'b0;
        tuning_phase_two_i = 1'b1;
        tick(2000);
        tuning_phase_two_i = 1'b0;
        n = 0;
        while (tuning_done_o !== 1'b1 && n < 5000)
        begin
            tick(1);
            n = n + 1;
        end
        chk(n < 5000, "tuning completion");
        if (n < 5000)
        begin
            chk(tuned_offset_readback_o > 8'h24, "offset tuned up");
            chk(tuned_gradient_readback_o > 8'h0e, "gradient tuned up");
            run_current_scale_i = 5'h02;
            tick(3);
            chk(current_scale_o === 5'h02, "sub-limit scale accepted");
        end
    endtask
    initial
    begin
        tick(6);
        sys_rst_i = 1'b0;
        tick(1);
        chk(tuned_offset_readback_o === 8'h24, "offset readback");
        chk(tuned_gradient_readback_o === 8'h0e, "gradient readback");
        chk(step_interval_count_o === 20'hfffff, "interval reset");
        t_velocity();
        t_steps();
        t_regulate();
        t_tuning();
        close_out();
    end
endmodule // vpar_regulator_tb
bind vpar_regulator vpar_regulator_monitor u_mon
(
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .step_pin_i(step_pin_i),
    .auto_scale_en_i(auto_scale_en_i),
    .standstill_i(standstill_i),
    .freewheel_en_i(freewheel_en_i),
    .run_current_scale_i(run_current_scale_i),
    .hold_current_scale_i(hold_current_scale_i),
    .total_amplitude_o(total_amplitude_o),
    .tuned_offset_readback_o(tuned_offset_readback_o),
    .tuned_gradient_readback_o(tuned_gradient_readback_o),
    .step_interval_count_o(step_interval_count_o),
    .current_scale_o(current_scale_o),
    .tuning_done_o(tuning_done_o),
    .amplitude_at_limit_o(amplitude_at_limit_o),
    .sine_peak_o(sine_peak_o)
);
